// ### design/aps_pkg.sv
package aps_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Register offsets, valid on the amplifier page
  localparam logic [7:0] REG_PAGE = 8'h00;
  localparam logic [7:0] RSVD_LO = 8'h01;
  localparam logic [7:0] RSVD_HI = 8'h1D;
  localparam logic [7:0] REG_ERR = 8'h1E;
  localparam logic [7:0] REG_HP = 8'h1F;
  localparam logic [7:0] REG_SPK = 8'h20;
  localparam logic [7:0] PAGE_AMP = 8'h01;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] ERR_RST = 8'h00;
  localparam logic [7:0] HP_RST = 8'h04;
  localparam logic [7:0] SPK_RST = 8'h06;
  // Field positions
  localparam int unsigned ERR_HP_KEEP = 1;
  localparam int unsigned ERR_SPK_KEEP = 0;
  localparam int unsigned HP_PWR = 7;
  localparam int unsigned HP_CM_LO = 3;
  localparam int unsigned HP_SC_PDN = 1;
  localparam int unsigned HP_SC_STAT = 0;
  localparam int unsigned SPK_PWR = 7;
  localparam int unsigned SPK_SC_STAT = 0;
  // Reserved-bit patterns the host must keep
  localparam logic [7:0] HP_RSV_ONE = 8'h04;
  localparam logic [7:0] HP_RSV_ZERO = 8'h20;
  localparam logic [7:0] SPK_RSV_MASK = 8'h7E;
  // Controller Wishbone map (byte addresses)
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam logic [7:0] WB_IRQ = 8'h08;
  localparam logic [7:0] WB_MASK = 8'h0C;
  localparam int unsigned CMD_ADR_LO = 8;
  localparam int unsigned CMD_WE = 16;
  localparam int unsigned STAT_BUSY = 8;
  localparam int unsigned STAT_PAGE_LO = 16;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_REFUSED = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [1:0] IRQ_RST = 2'h0;
  typedef enum logic {APS_IDLE, APS_BUSY} aps_host_state_t;
endpackage : aps_pkg

// ### design/aps_link_if.sv
`timescale 1ns/1ps
interface aps_link_if;
  logic req;
  logic we;
  logic [aps_pkg::ADDR_W-1:0] addr;
  logic [aps_pkg::DATA_W-1:0] wdata;
  logic ack;
  logic [aps_pkg::DATA_W-1:0] rdata;
  modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : aps_link_if

// ### design/aps_amp_regs.sv
// Notes on behaviour
// - Page selector picks page, resets to zero
// - Host never writes addresses one to 29 while page one is selected
// - Short clears headphone power unless kept; here only with response set
// - Keep bit set leaves headphone power
// - Speaker keep bit set leaves speaker power
// - Headphone bit seven powers driver
// - Two bits choose headphone common mode
// - Host writes one into headphone D2
// - Host writes zero into headphone D5
// - Response clear: limit load current
// - Response set: power driver down
// - Headphone status reads live short
// - Speaker bit seven powers class-D driver
// - Host writes speaker reserved reset pattern
// - Speaker status reads short while powered
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module aps_amp_regs #(
  parameter int unsigned PAGE_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  aps_link_if.dev link,
  input wire logic hp_short_det,
  input wire logic hp_protect_en,
  input wire logic spk_short_det,
  output logic headphone_output_on,
  output logic [1:0] hp_cm_level,
  output logic hp_current_limit,
  output logic speaker_path_left_on,
  output logic speaker_path_right_on,
  output logic [7:0] page_sel
);

  if (PAGE_W != 8) begin : g_chk
    $error("aps_amp_regs: PAGE_W must be 8");
  end

  // Stored bits are D7..D1; D0 is the live status bit
  if (aps_pkg::HP_CM_LO < 1 || aps_pkg::HP_CM_LO > 6) begin : g_fld_chk
    $error("aps_amp_regs: common-mode field outside stored bits");
  end

  localparam int unsigned SPK_PATHS = 2;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] page_reg;
  logic [7:0] err_reg;
  logic [7:1] hp_reg;
  logic [7:1] spk_reg;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic acc;
  logic wr;
  logic on_amp;
  logic hp_trip;
  logic hp_down;
  logic hp_clear;
  logic spk_short_seen;
  logic spk_clear;
  logic [7:0] rd_next;

  // One access per request; the held request is not taken twice
  assign acc = link.req & ~ack_reg;
  assign wr = acc & link.we;
  assign on_amp = (page_reg == aps_pkg::PAGE_AMP);

  assign hp_trip = hp_protect_en & hp_short_det;
  assign hp_down = hp_trip & hp_reg[aps_pkg::HP_SC_PDN];
  assign hp_clear = hp_down & ~err_reg[aps_pkg::ERR_HP_KEEP];
  assign spk_short_seen = spk_short_det & spk_reg[aps_pkg::SPK_PWR];
  assign spk_clear = spk_short_seen & ~err_reg[aps_pkg::ERR_SPK_KEEP];

  ////////////////////////////////////////////////////////////////////////////
  // page select
  always_ff @(posedge clk) begin
    if (!nrst) begin
      page_reg <= aps_pkg::PAGE_RST;
    end else if (wr && link.addr == aps_pkg::REG_PAGE) begin
      page_reg <= link.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      err_reg <= aps_pkg::ERR_RST;
    end else if (wr && on_amp && link.addr == aps_pkg::REG_ERR) begin
      err_reg <= link.wdata;
    end
  end

  // Hardware clear beats a same-cycle power-up write: protection first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hp_reg <= aps_pkg::HP_RST[7:1];
    end else begin
      if (wr && on_amp && link.addr == aps_pkg::REG_HP) begin
        hp_reg <= link.wdata[7:1];
      end
      if (hp_clear) begin
        hp_reg[aps_pkg::HP_PWR] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      spk_reg <= aps_pkg::SPK_RST[7:1];
    end else begin
      if (wr && on_amp && link.addr == aps_pkg::REG_SPK) begin
        spk_reg <= link.wdata[7:1];
      end
      if (spk_clear) begin
        spk_reg[aps_pkg::SPK_PWR] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reserved and unmapped locations read zero, writes ignored
  always_comb begin
    rd_next = 8'h00;
    if (link.addr == aps_pkg::REG_PAGE) begin
      rd_next = page_reg;
    end else if (on_amp) begin
      unique case (link.addr)
        aps_pkg::REG_ERR: rd_next = err_reg;
        aps_pkg::REG_HP: rd_next = {hp_reg, hp_short_det};
        aps_pkg::REG_SPK: rd_next = {spk_reg, spk_short_seen};
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= acc;
      if (acc) begin
        rdata_reg <= rd_next;
      end
    end
  end

  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // driver down on trip when the response bit selects power-down
  always_ff @(posedge clk) begin
    if (!nrst) begin
      headphone_output_on <= 1'b0;
    end else begin
      headphone_output_on <= hp_reg[aps_pkg::HP_PWR] & ~hp_down;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hp_cm_level <= 2'h0;
    end else begin
      hp_cm_level <= hp_reg[aps_pkg::HP_CM_LO+1:aps_pkg::HP_CM_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hp_current_limit <= 1'b0;
    end else begin
      hp_current_limit <= hp_trip & ~hp_reg[aps_pkg::HP_SC_PDN];
    end
  end

  // both paths follow one power bit
  for (genvar g = 0; g < SPK_PATHS; g++) begin : g_spk
    logic on_reg;
    always_ff @(posedge clk) begin
      if (!nrst) begin
        on_reg <= 1'b0;
      end else begin
        on_reg <= spk_reg[aps_pkg::SPK_PWR];
      end
    end
  end

  assign speaker_path_left_on = g_spk[0].on_reg;
  assign speaker_path_right_on = g_spk[1].on_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      page_sel <= aps_pkg::PAGE_RST;
    end else begin
      page_sel <= page_reg;
    end
  end

endmodule : aps_amp_regs

// ### design/aps_amp_host.sv
`timescale 1ns/1ps
module aps_amp_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  aps_link_if.host link
);

  ////////////////////////////////////////////////////////////////////////////
  aps_pkg::aps_host_state_t state_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic req_reg;
  logic we_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic [7:0] page_reg;
  logic [aps_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [aps_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [aps_pkg::IRQ_W-1:0] ev;
  logic wb_take;
  logic cmd_wr;
  logic cmd_we;
  logic [7:0] cmd_adr;
  logic [7:0] cmd_dat;
  logic refuse;
  logic [7:0] fixed_dat;
  logic done;

  assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  // Command needs its three low lanes; a partial write is ignored
  assign cmd_wr = wb_take & wb_we_i & (wb_adr_i == aps_pkg::WB_CMD)
    & (&wb_sel_i[2:0]) & (state_reg == aps_pkg::APS_IDLE);
  assign cmd_we = wb_dat_i[aps_pkg::CMD_WE];
  assign cmd_adr = wb_dat_i[aps_pkg::CMD_ADR_LO+7:aps_pkg::CMD_ADR_LO];
  assign cmd_dat = wb_dat_i[7:0];
  assign refuse = cmd_we && page_reg == aps_pkg::PAGE_AMP
    && cmd_adr >= aps_pkg::RSVD_LO && cmd_adr <= aps_pkg::RSVD_HI;
  assign done = (state_reg == aps_pkg::APS_BUSY) & link.ack;

  always_comb begin
    fixed_dat = cmd_dat;
    if (page_reg == aps_pkg::PAGE_AMP && cmd_adr == aps_pkg::REG_HP) begin
      fixed_dat = (cmd_dat | aps_pkg::HP_RSV_ONE) & ~aps_pkg::HP_RSV_ZERO;
    end else if (page_reg == aps_pkg::PAGE_AMP && cmd_adr == aps_pkg::REG_SPK) begin
      fixed_dat = (cmd_dat & ~aps_pkg::SPK_RSV_MASK)
        | (aps_pkg::SPK_RST & aps_pkg::SPK_RSV_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= aps_pkg::APS_IDLE;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        aps_pkg::APS_IDLE: begin
          if (cmd_wr && !refuse) begin
            state_reg <= aps_pkg::APS_BUSY;
            req_reg <= 1'b1;
            we_reg <= cmd_we;
            addr_reg <= cmd_adr;
            wdata_reg <= fixed_dat;
          end
        end
        aps_pkg::APS_BUSY: begin
          if (link.ack) begin
            state_reg <= aps_pkg::APS_IDLE;
            req_reg <= 1'b0;
            rdata_reg <= link.rdata;
          end
        end
      endcase
    end
  end

  // Shadow of the device page, so the guards know where writes land
  always_ff @(posedge clk) begin
    if (!nrst) begin
      page_reg <= aps_pkg::PAGE_RST;
    end else if (done && we_reg && addr_reg == aps_pkg::REG_PAGE) begin
      page_reg <= wdata_reg;
    end
  end

  assign link.req = req_reg;
  assign link.we = we_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  assign ev = {cmd_wr & refuse, done};

  // Read clears; an event in the same cycle survives
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat_reg <= aps_pkg::IRQ_RST;
    end else if (wb_take && !wb_we_i && wb_adr_i == aps_pkg::WB_IRQ) begin
      irq_stat_reg <= ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_mask_reg <= aps_pkg::IRQ_RST;
    end else if (wb_take && wb_we_i && wb_adr_i == aps_pkg::WB_MASK && wb_sel_i[0]) begin
      irq_mask_reg <= wb_dat_i[aps_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= wb_take;
      wb_dat_reg <= 32'h0000_0000;
      if (wb_take && !wb_we_i) begin
        unique case (wb_adr_i)
          aps_pkg::WB_STAT: begin
            wb_dat_reg[7:0] <= rdata_reg;
            wb_dat_reg[aps_pkg::STAT_BUSY] <= (state_reg == aps_pkg::APS_BUSY);
            wb_dat_reg[aps_pkg::STAT_PAGE_LO+7:aps_pkg::STAT_PAGE_LO] <= page_reg;
          end
          aps_pkg::WB_IRQ: wb_dat_reg[aps_pkg::IRQ_W-1:0] <= irq_stat_reg;
          aps_pkg::WB_MASK: wb_dat_reg[aps_pkg::IRQ_W-1:0] <= irq_mask_reg;
          default: wb_dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

endmodule : aps_amp_host

// ### sim/aps_link_chk.sv
`timescale 1ns/1ps
module aps_link_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  logic [7:0] pg_reg;
  logic tk;
  logic p1;
  assign tk = req && !ack;
  assign p1 = pg_reg == aps_pkg::PAGE_AMP;
  // Own copy of the page, so page 1 checks need no design internals
  always_ff @(posedge clk) begin
    if (!nrst) pg_reg <= 8'h00;
    else if (tk && we && addr == aps_pkg::REG_PAGE) pg_reg <= wdata;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(a); tk && we && p1 && addr == a; endsequence
  sequence s_rd(a); tk && !we && p1 && addr == a; endsequence
  property p_ack; tk |=> ack ##1 !ack; endproperty
  a_ack: assert property (p_ack) else $error("link ack timing");
  property p_hold; tk |=> req && $stable(addr) && $stable(wdata); endproperty
  a_hold: assert property (p_hold) else $error("link request not held");
  property p_page; tk && !we && addr == aps_pkg::REG_PAGE |=> rdata == pg_reg; endproperty
  a_page: assert property (p_page) else $error("page readback");
  property p_rsvd; tk && we && p1 |-> addr < 8'h01 || addr > 8'h1D; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved write");
  property p_hp_wr; s_wr(8'h1F) |-> wdata[2] && !wdata[5]; endproperty
  a_hp_wr: assert property (p_hp_wr) else $error("hp reserved write");
  property p_spk_wr; s_wr(8'h20) |-> wdata[6:1] == 6'h03; endproperty
  a_spk_wr: assert property (p_spk_wr) else $error("spk reserved write");
  property p_hp_rd; s_rd(8'h1F) |=> rdata[2] && !rdata[5]; endproperty
  a_hp_rd: assert property (p_hp_rd) else $error("hp reserved read");
  property p_spk_rd; s_rd(8'h20) |=> rdata[6:1] == 6'h03; endproperty
  a_spk_rd: assert property (p_spk_rd) else $error("spk reserved read");
endmodule : aps_link_chk

// ### sim/amp_power_short_protect_regs_tb.sv
`timescale 1ns/1ps
module amp_power_short_protect_regs_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wwe = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic hs = 1'b0;
  logic hp = 1'b0;
  logic ss = 1'b0;
  logic [31:0] rdat;
  logic wack, irq, hon, hlim, sl, sr;
  logic [1:0] cm;
  logic [7:0] pg;
  int failures = 0;
  int cmp_count = 0;
  aps_link_if link();
  aps_amp_regs u_aps_amp_regs (.clk(clk), .nrst(nrst), .link(link), .hp_short_det(hs),
    .hp_protect_en(hp), .spk_short_det(ss), .headphone_output_on(hon), .hp_cm_level(cm),
    .hp_current_limit(hlim), .speaker_path_left_on(sl), .speaker_path_right_on(sr),
    .page_sel(pg));
  aps_amp_host u_aps_amp_host (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(wack), .irq(irq), .link(link));
  aps_link_chk u_aps_link_chk (.clk(clk), .nrst(nrst), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang;
    failures++;
    $display("Error %0t: wait ran out", $time);
    test_done();
  endtask : hang
  // Ack and read data are taken at the rising edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
      if (n > 40) hang();
    end while (wack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    wb(1'b1, aps_pkg::WB_CMD, {15'h0, w, a, d}, q);
    do begin
      wb(1'b0, aps_pkg::WB_STAT, 32'h0, q);
      n++;
      if (n > 20) hang();
    end while (q[8] !== 1'b0);
  endtask : cmd
  task automatic sh(input logic p, input logic h, input logic k);
    @(posedge clk);
    hp <= p;
    hs <= h;
    ss <= k;
  endtask : sh
  ////////////////////////////////////////////////////////////////
  task automatic t_page;
    logic [31:0] s;
    cmd(1'b0, 8'h00, 8'h00, s);
    chk(s[7:0], 8'h00);
    cmd(1'b1, 8'h00, 8'hFF, s);
    chk(s[23:16], 8'hFF);
    chk(pg, 8'hFF);
    cmd(1'b1, 8'h00, 8'h01, s);
    chk(pg, 8'h01);
  endtask : t_page
  task automatic t_hp;
    logic [31:0] s;
    cmd(1'b0, 8'h1F, 8'h00, s);
    chk(s[7:0], 8'h04);
    cmd(1'b0, 8'h20, 8'h00, s);
    chk(s[7:0], 8'h06);
    // Bad reserved bits on purpose: the host must correct them
    for (int i = 0; i < 4; i++) begin
      cmd(1'b1, 8'h1F, 8'hA0 | 8'(i << 3), s);
      cmd(1'b0, 8'h1F, 8'h00, s);
      chk(s[7:0], 8'h84 | 8'(i << 3));
      chk({6'h0, cm}, 8'(i));
      chk({7'h0, hon}, 8'h01);
    end
    cmd(1'b1, 8'h1F, 8'h04, s);
    chk({7'h0, hon}, 8'h00);
  endtask : t_hp
  task automatic t_irq;
    logic [31:0] s;
    wb(1'b0, aps_pkg::WB_IRQ, 32'h0, s);
    cmd(1'b1, 8'h05, 8'h55, s);
    chk({7'h0, irq}, 8'h00);
    wb(1'b1, aps_pkg::WB_MASK, 32'h2, s);
    @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    wb(1'b0, aps_pkg::WB_IRQ, 32'h0, s);
    chk({7'h0, s[1]}, 8'h01);
    @(negedge clk);
    chk({7'h0, irq}, 8'h00);
  endtask : t_irq
  task automatic t_short;
    logic [31:0] s;
    cmd(1'b1, 8'h1E, 8'h00, s);
    cmd(1'b1, 8'h1F, 8'h86, s);
    sh(1'b1, 1'b1, 1'b0);
    cmd(1'b0, 8'h1F, 8'h00, s);
    chk(s[7:0], 8'h07);
    chk({7'h0, hon}, 8'h00);
    sh(1'b1, 1'b0, 1'b0);
    cmd(1'b1, 8'h1E, 8'h02, s);
    cmd(1'b1, 8'h1F, 8'h86, s);
    sh(1'b1, 1'b1, 1'b0);
    cmd(1'b0, 8'h1F, 8'h00, s);
    chk(s[7:0], 8'h87);
    chk({7'h0, hon}, 8'h00);
    sh(1'b1, 1'b0, 1'b0);
    cmd(1'b1, 8'h1F, 8'h84, s);
    sh(1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk({6'h0, hlim, hon}, 8'h03);
    sh(1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk({7'h0, hlim}, 8'h00);
  endtask : t_short
  task automatic t_spk;
    logic [31:0] s;
    sh(1'b0, 1'b0, 1'b0);
    cmd(1'b1, 8'h1E, 8'h00, s);
    cmd(1'b1, 8'h20, 8'h86, s);
    chk({6'h0, sl, sr}, 8'h03);
    sh(1'b0, 1'b0, 1'b1);
    cmd(1'b0, 8'h20, 8'h00, s);
    chk(s[7:0], 8'h06);
    chk({6'h0, sl, sr}, 8'h00);
    sh(1'b0, 1'b0, 1'b0);
    cmd(1'b1, 8'h1E, 8'h01, s);
    cmd(1'b1, 8'h20, 8'h86, s);
    sh(1'b0, 1'b0, 1'b1);
    cmd(1'b0, 8'h20, 8'h00, s);
    chk(s[7:0], 8'h87);
    chk({6'h0, sl, sr}, 8'h03);
  endtask : t_spk
  // Mid-run reset with drivers up and a speaker short still present
  task automatic t_reset;
    logic [31:0] s;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(pg, 8'h00);
    chk({6'h0, sl, sr}, 8'h00);
    cmd(1'b1, 8'h00, 8'h01, s);
    cmd(1'b0, 8'h1F, 8'h00, s);
    chk(s[7:0], 8'h04);
    cmd(1'b0, 8'h20, 8'h00, s);
    chk(s[7:0], 8'h06);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_page();
    t_hp();
    t_irq();
    t_short();
    t_spk();
    t_reset();
    test_done();
  end
endmodule : amp_power_short_protect_regs_tb
